// File: pcos_top.sv
// Purpose: One axis of pulse command output with shared start and stop.
// Assumes: All inputs are synchronous to CLK; the shared lines are wired
//          open drain outside and read back as the resolved wire level.
// Notes: Configuration is latched when a move is loaded and holds for it.

`timescale 1ns/10ps

// What this block does
// R01 - In pulse/direction mode each commanded step is one pulse on the pulse pin.
// R02 - The number of pulses emitted equals the commanded distance.
// R03 - Pulses are issued at the commanded rate, one per programmed period; periods below MIN_PERIOD (2 cycles) are raised to 2.
// R04 - In pulse/direction mode the direction pin is a steady level.
// R05 - In dual mode positive steps pulse the first pin, negative the second.
// R06 - In quadrature mode the first pin leads for plus, the second for minus.
// R07 - A mode setting chooses among the three modes for both pins.
// R08 - Pulse polarity can be chosen as active high or active low.
// R09 - The shared start and stop lines are each sensed and can be driven.
// R10 - Software can assert either shared line so that all axes see it.
// R11 - An outside source drives the shared lines only by pulling them low.
// R12 - Armed axes start, and running axes halt, in the cycle a line is seen.
module pcos_top
    import pcos_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Move command
    input wire logic CMD_LOAD,
    input wire logic [pcos_pkg::DIST_W-1:0] CMD_DIST,
    input wire logic [pcos_pkg::PER_W-1:0] CMD_PERIOD,
    input wire logic CMD_DIR,
    input wire logic CMD_SYNC,
    // Configuration
    input wire logic [1:0] CFG_MODE,
    input wire logic CFG_POL,
    // Software requests for the shared lines
    input wire logic SW_START,
    input wire logic SW_STOP,
    // Shared start line
    input wire logic SYNC_START_LINE_N_IN,
    output logic SYNC_START_LINE_N_OUT,
    output logic SYNC_START_LINE_OE,
    // Shared stop line
    input wire logic SYNC_STOP_LINE_N_IN,
    output logic SYNC_STOP_LINE_N_OUT,
    output logic SYNC_STOP_LINE_OE,
    // Driver pins and status
    output logic PULSE_OUT,
    output logic DIR_OUT,
    output logic BUSY
);
    import pcos_pkg::*;

    pcos_regs_t s_r;
    pcos_regs_t s_nxt;
    logic start_seen;
    logic stop_seen;
    logic go_run;
    logic step_start;
    logic done_evt;

    // ************************************************************
    // Shared line sensing
    // ************************************************************
    // A low wire level means asserted, whoever pulls it.
    assign start_seen = !SYNC_START_LINE_N_IN; // R09
    assign stop_seen = !SYNC_STOP_LINE_N_IN; // R09
    assign go_run = (s_r.state == PCOS_RUN)
        || (s_r.state == PCOS_ARMED && start_seen); // R12
    assign step_start = go_run && !stop_seen && s_r.cnt == '0
        && s_r.remain != '0;
    assign done_evt = s_r.state == PCOS_RUN && !stop_seen
        && s_r.cnt == '0 && s_r.remain == '0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.line_lvl = 1'b0;
        unique case (s_r.state)
            PCOS_IDLE:
            begin
                if (CMD_LOAD && CMD_DIST != '0)
                begin
                    s_nxt.remain = CMD_DIST;
                    s_nxt.period = (CMD_PERIOD < MIN_PERIOD) ?
                        MIN_PERIOD : CMD_PERIOD;
                    s_nxt.mode = CFG_MODE; // R07
                    s_nxt.pol = CFG_POL; // R08
                    s_nxt.dir = CMD_DIR;
                    s_nxt.cnt = '0;
                    s_nxt.state = CMD_SYNC ? PCOS_ARMED : PCOS_RUN;
                end
            end
            PCOS_ARMED:
            begin
                if (stop_seen)
                begin
                    s_nxt.state = PCOS_IDLE; // R12
                end
                else if (start_seen)
                begin
                    s_nxt.state = PCOS_RUN; // R12
                end
            end
            PCOS_RUN:
            begin
                if (stop_seen || done_evt)
                begin
                    s_nxt.state = PCOS_IDLE; // R12
                end
            end
            default:
            begin
                s_nxt.state = PCOS_IDLE;
            end
        endcase

        // Step timing: one step per period, high for the upper half.
        if (stop_seen || !go_run)
        begin
            s_nxt.act = 1'b0;
        end
        else if (step_start)
        begin
            s_nxt.remain = s_r.remain - 1'b1; // R02
            s_nxt.cnt = s_r.period - 1'b1; // R03
            s_nxt.act = 1'b1;
            s_nxt.quad = s_r.dir ? s_r.quad + 1'b1 : s_r.quad - 1'b1; // R06
        end
        else if (s_r.cnt != '0)
        begin
            s_nxt.cnt = s_r.cnt - 1'b1; // R03
            s_nxt.act = (s_r.cnt - 1'b1) >= (s_r.period >> 1);
        end
        else
        begin
            s_nxt.act = 1'b0;
        end
        s_nxt.busy = s_nxt.state != PCOS_IDLE;

        // Pin mapping by mode. The pins follow the newly loaded setting
        // from the load edge on, so the inactive level and the direction
        // stand for a cycle before the first pulse and no edge is lost.
        case (s_nxt.mode) // R07
            MODE_DUAL:
            begin
                s_nxt.pin_a = (s_nxt.act && s_nxt.dir) ^ s_nxt.pol; // R05
                s_nxt.pin_b = (s_nxt.act && !s_nxt.dir) ^ s_nxt.pol; // R05
            end
            MODE_AB:
            begin
                s_nxt.pin_a = s_nxt.quad[1] ^ s_nxt.quad[0]
                    ^ s_nxt.pol; // R06
                s_nxt.pin_b = s_nxt.quad[1] ^ s_nxt.pol; // R06
            end
            default:
            begin
                s_nxt.pin_a = s_nxt.act ^ s_nxt.pol; // R01
                s_nxt.pin_b = s_nxt.dir; // R04
            end
        endcase

        // Software assertion of the shared lines, held for a fixed time.
        if (SW_START)
        begin
            s_nxt.sta_oe = 1'b1; // R10
            s_nxt.sta_cnt = SYNC_ASSERT_LAST;
        end
        else if (s_r.sta_cnt != '0)
        begin
            s_nxt.sta_cnt = s_r.sta_cnt - 1'b1;
        end
        else
        begin
            s_nxt.sta_oe = 1'b0;
        end
        if (SW_STOP)
        begin
            s_nxt.stp_oe = 1'b1; // R10
            s_nxt.stp_cnt = SYNC_ASSERT_LAST;
        end
        else if (s_r.stp_cnt != '0)
        begin
            s_nxt.stp_cnt = s_r.stp_cnt - 1'b1;
        end
        else
        begin
            s_nxt.stp_oe = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_r <= '{state: PCOS_IDLE, mode: MODE_RST, pol: POL_RST,
                     dir: DIR_RST, pin_a: POL_RST, pin_b: DIR_RST,
                     default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Lines are only ever pulled low; the level driven is always zero.
    assign SYNC_START_LINE_N_OUT = s_r.line_lvl; // R09
    assign SYNC_STOP_LINE_N_OUT = s_r.line_lvl; // R09
    assign SYNC_START_LINE_OE = s_r.sta_oe; // R10
    assign SYNC_STOP_LINE_OE = s_r.stp_oe; // R10
    assign PULSE_OUT = s_r.pin_a;
    assign DIR_OUT = s_r.pin_b;
    assign BUSY = s_r.busy;

    // ************************************************************
    // Checking helpers
    // ************************************************************
    logic [DIST_W-1:0] dist_r;
    logic [DIST_W-1:0] emitted_r;
    logic [PER_W-1:0] since_r;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            dist_r <= '0;
            emitted_r <= '0;
            since_r <= '0;
        end
        else
        begin
            if (s_r.state == PCOS_IDLE && CMD_LOAD)
            begin
                dist_r <= CMD_DIST;
                emitted_r <= '0;
            end
            else if (step_start)
            begin
                emitted_r <= emitted_r + 1'b1;
            end
            if (step_start)
            begin
                since_r <= 16'h0001;
            end
            else if (since_r != 16'hffff)
            begin
                since_r <= since_r + 1'b1;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence seq_armed_start;
        s_r.state == PCOS_ARMED && start_seen && !stop_seen;
    endsequence

    sequence seq_first_pulse;
        s_r.state == PCOS_RUN && BUSY && s_r.act;
    endsequence

    a_single_pulse_out: assert property ( // R01
        step_start && s_r.mode == MODE_SINGLE |=> PULSE_OUT == !s_r.pol)
        else $error("single mode step did not raise the pulse pin");

    a_count_done: assert property ( // R02
        done_evt |-> emitted_r == dist_r)
        else $error("pulse count differs from commanded distance");

    a_step_period: assert property ( // R03
        step_start && s_r.remain != dist_r |-> since_r == s_r.period)
        else $error("step spacing differs from programmed period");

    a_dir_static: assert property ( // R04
        s_r.mode == MODE_SINGLE && BUSY && $past(BUSY)
        |-> $stable(DIR_OUT))
        else $error("direction pin moved during a single mode move");

    a_dual_exclusive: assert property ( // R05
        s_r.mode == MODE_DUAL
        |-> !(PULSE_OUT != s_r.pol && DIR_OUT != s_r.pol))
        else $error("both dual mode pins active together");

    a_quad_one_edge: assert property ( // R06
        step_start && s_r.mode == MODE_AB
        |=> (PULSE_OUT ^ $past(PULSE_OUT)) != (DIR_OUT ^ $past(DIR_OUT)))
        else $error("quadrature step did not change exactly one pin");

    a_idle_level: assert property ( // R08
        !BUSY && $past(!BUSY) && s_r.mode != MODE_AB
        |-> PULSE_OUT == s_r.pol)
        else $error("idle pulse pin not at inactive polarity");

    a_sw_start_drive: assert property ( // R10
        SW_START |=> (SYNC_START_LINE_OE && !SYNC_START_LINE_N_OUT) [*8])
        else $error("software start did not hold the line low");

    a_sw_stop_drive: assert property ( // R10
        SW_STOP |=> SYNC_STOP_LINE_OE [*8])
        else $error("software stop did not hold the line");

    a_sync_start_go: assert property ( // R12
        seq_armed_start |=> seq_first_pulse)
        else $error("armed axis did not start on the start line");

    a_sync_stop_halt: assert property ( // R12
        stop_seen && BUSY |=> !BUSY && !s_r.act)
        else $error("axis did not halt on the stop line");

endmodule // pcos_top

// File: pcos_pkg.sv
// Purpose: Shared constants and types for the pulse command output block.
// Assumes: One 40 MHz system clock; shared lines are active low, open drain.
// Notes: Mode codes and the state encoding are used by the block and tests.

package pcos_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int DIST_W = 24;
    localparam int PER_W = 16;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYNC_ASSERT_NS = 1000;
    localparam int SYNC_ASSERT_CYC =
        (SYNC_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SYNC_ASSERT_LAST = 8'(SYNC_ASSERT_CYC - 1);
    localparam logic [PER_W-1:0] MIN_PERIOD = 16'h0002;

    // ************************************************************
    // Output modes
    // ************************************************************
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_AB = 2'h2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic POL_RST = 1'b0;
    localparam logic DIR_RST = 1'b1;

    // ************************************************************
    // States and block state
    // ************************************************************
    typedef enum logic [2:0] {
        PCOS_IDLE = 3'b001,
        PCOS_ARMED = 3'b010,
        PCOS_RUN = 3'b100
    } pcos_state_t;

    typedef struct packed {
        pcos_state_t state;
        logic [DIST_W-1:0] remain;
        logic [PER_W-1:0] cnt;
        logic [PER_W-1:0] period;
        logic [1:0] mode;
        logic pol;
        logic dir;
        logic act;
        logic [1:0] quad;
        logic pin_a;
        logic pin_b;
        logic busy;
        logic [7:0] sta_cnt;
        logic sta_oe;
        logic [7:0] stp_cnt;
        logic stp_oe;
        logic line_lvl;
    } pcos_regs_t;

endpackage : pcos_pkg

// File: pcos_drv_model.sv
// Purpose: Motor driver model that counts the command pulses it receives.
// Assumes: Pins are sampled on CLK; pol gives the inactive pin level.
// Notes: Counters clear when a move begins, at the first BUSY cycle.

`timescale 1ns/10ps

module pcos_drv_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Driver pins and move status
    input wire logic busy,
    input wire logic pin_a,
    input wire logic pin_b,
    input wire logic pol,
    // Observed motion
    output int cnt_a,
    output int cnt_b,
    output int qpos,
    output int both
);
    logic a_r, b_r, busy_r, a, b;
    logic [1:0] step;

    // Quadrature index: 00, 10, 11, 01 count up for plus travel.
    function automatic logic [1:0] gidx(input logic x, input logic y);
        return {y, x ^ y};
    endfunction

    assign a = pin_a ^ pol;
    assign b = pin_b ^ pol;
    assign step = gidx(a, b) - gidx(a_r, b_r);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // The second pin idles high after reset; match it here.
            {a_r, b_r, busy_r} <= 3'h2;
            {cnt_a, cnt_b, qpos, both} <= '0;
        end
        else
        begin
            a_r <= a;
            b_r <= b;
            busy_r <= busy;
            if (busy && !busy_r)
            begin
                {cnt_a, cnt_b, qpos, both} <= '0;
            end
            else
            begin
                if (a && !a_r) cnt_a <= cnt_a + 1;
                if (b && !b_r) cnt_b <= cnt_b + 1;
                if (a && b) both <= both + 1;
                if (step == 2'h1) qpos <= qpos + 1;
                else if (step == 2'h3) qpos <= qpos - 1;
            end
        end
    end
endmodule // pcos_drv_model

// File: pcos_tb.sv
// Purpose: Self-checking bench for one pulse command output axis.
// Assumes: Shared lines resolve open drain here; outside pulls are low only.
// Notes: Each scenario task drives a move and judges the driver's counts or the axis outputs.

`timescale 1ns/10ps

`define CHK(got, exp) begin total_checks++; \
    if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module testbench;
    import pcos_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, cmd_load = 1'b0, cmd_dir = 1'b1;
    logic cmd_sync = 1'b0, cfg_pol = 1'b0, sw_start = 1'b0, sw_stop = 1'b0;
    logic ext_start = 1'b0, ext_stop = 1'b0, start_n, stop_n;
    logic [DIST_W-1:0] cmd_dist = '0;
    logic [PER_W-1:0] cmd_period = 16'h0004;
    logic [1:0] cfg_mode = 2'h0;
    logic sta_out, sta_oe, stp_out, stp_oe, pulse_out, dir_out, busy;
    int cnt_a, cnt_b, qpos, both, cyc, dir_flip, bad_count = 0;
    int total_checks = 0;

    always #12.5 clk = ~clk;

    // Only a low pull exists on each line, from the axis or outside.
    assign start_n = !((sta_oe && !sta_out) || ext_start);
    assign stop_n = !((stp_oe && !stp_out) || ext_stop);

    pcos_top i_pcos_top (.CLK(clk), .RESETN(resetn), .CMD_LOAD(cmd_load),
        .CMD_DIST(cmd_dist), .CMD_PERIOD(cmd_period), .CMD_DIR(cmd_dir),
        .CMD_SYNC(cmd_sync), .CFG_MODE(cfg_mode), .CFG_POL(cfg_pol),
        .SW_START(sw_start), .SW_STOP(sw_stop),
        .SYNC_START_LINE_N_IN(start_n), .SYNC_START_LINE_N_OUT(sta_out),
        .SYNC_START_LINE_OE(sta_oe), .SYNC_STOP_LINE_N_IN(stop_n),
        .SYNC_STOP_LINE_N_OUT(stp_out), .SYNC_STOP_LINE_OE(stp_oe),
        .PULSE_OUT(pulse_out), .DIR_OUT(dir_out), .BUSY(busy));

    pcos_drv_model i_pcos_drv_model (.clk(clk), .rst_n(resetn),
        .busy(busy), .pin_a(pulse_out), .pin_b(dir_out), .pol(cfg_pol),
        .cnt_a(cnt_a), .cnt_b(cnt_b), .qpos(qpos), .both(both));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic load(input logic [1:0] m, input logic p, d, s,
        input logic [DIST_W-1:0] n, input logic [PER_W-1:0] per);
        @(posedge clk);
        {cfg_mode, cfg_pol, cmd_dir, cmd_sync} <= {m, p, d, s};
        cmd_dist <= n;
        cmd_period <= per;
        cmd_load <= 1'b1;
        @(posedge clk);
        cmd_load <= 1'b0;
    endtask

    // Counts BUSY cycles and every cycle the direction pin differs from cmd_dir until the move ends.
    task automatic wait_idle();
        cyc = 0;
        dir_flip = 0;
        @(negedge clk);
        while (busy === 1'b1 && cyc < 3000)
        begin
            cyc++;
            if (dir_out !== cmd_dir) dir_flip++;
            @(negedge clk);
        end
    endtask

    // Pulls a shared line for one cycle; t_line is 0 start, 1 stop.
    task automatic pull(input logic t_line);
        @(posedge clk);
        if (t_line) ext_stop <= 1'b1;
        else ext_start <= 1'b1;
        @(posedge clk);
        {ext_start, ext_stop} <= 2'b00;
        @(negedge clk);
    endtask

    task automatic count_oe(input logic t_line);
        cyc = 0;
        @(negedge clk);
        while ((t_line ? stp_oe : sta_oe) === 1'b1 && cyc < 100)
        begin
            cyc++;
            @(negedge clk);
        end
    endtask

    task automatic t_single();
        load(2'h0, 1'b0, 1'b1, 1'b0, 24'h000003, 16'h0004);
        wait_idle();
        `CHK(cyc, 13)
        `CHK(cnt_a, 3)
        `CHK(cnt_b, 0)
        `CHK(dir_flip, 0)
        load(2'h3, 1'b1, 1'b0, 1'b0, 24'h000002, 16'h0005);
        wait_idle();
        `CHK(cyc, 11)
        `CHK(cnt_a, 2)
        `CHK(dir_flip, 0)
        load(2'h0, 1'b0, 1'b1, 1'b0, 24'h000002, 16'h0001);
        wait_idle();
        `CHK(cyc, 5)
        $display("test single done");
    endtask

    task automatic t_dual();
        load(2'h1, 1'b0, 1'b1, 1'b0, 24'h000003, 16'h0004);
        wait_idle();
        `CHK(cnt_a, 3)
        `CHK(cnt_b, 0)
        load(2'h1, 1'b1, 1'b0, 1'b0, 24'h000002, 16'h0003);
        wait_idle();
        `CHK(cyc, 7)
        `CHK(cnt_a, 0)
        `CHK(cnt_b, 2)
        `CHK(both, 0)
        $display("test dual done");
    endtask

    task automatic t_quad();
        load(2'h2, 1'b0, 1'b1, 1'b0, 24'h000005, 16'h0004);
        wait_idle();
        `CHK(qpos, 5)
        load(2'h2, 1'b1, 1'b0, 1'b0, 24'h000006, 16'h0002);
        wait_idle();
        `CHK(qpos, -6)
        $display("test quad done");
    endtask

    task automatic t_sync();
        load(2'h0, 1'b0, 1'b1, 1'b1, 24'h000002, 16'h0004);
        repeat (6) @(negedge clk);
        `CHK(busy, 1'b1)
        `CHK(cnt_a, 0)
        pull(1'b0);
        `CHK(pulse_out, 1'b1)
        wait_idle();
        `CHK(cnt_a, 2)
        load(2'h0, 1'b0, 1'b1, 1'b1, 24'h000002, 16'h0004);
        @(posedge clk);
        sw_start <= 1'b1;
        @(posedge clk);
        sw_start <= 1'b0;
        count_oe(1'b0);
        `CHK(cyc, SYNC_ASSERT_CYC)
        `CHK(cnt_a, 2)
        `CHK(busy, 1'b0)
        $display("test sync start done");
    endtask

    task automatic t_stop();
        load(2'h0, 1'b0, 1'b1, 1'b0, 24'h0000c8, 16'h0004);
        repeat (10) @(negedge clk);
        load(2'h0, 1'b0, 1'b0, 1'b0, 24'h000005, 16'h0004);
        @(negedge clk);
        `CHK(dir_out, 1'b1)
        pull(1'b1);
        `CHK(busy, 1'b0)
        `CHK(pulse_out, 1'b0)
        @(posedge clk);
        sw_stop <= 1'b1;
        @(posedge clk);
        sw_stop <= 1'b0;
        count_oe(1'b1);
        `CHK(cyc, SYNC_ASSERT_CYC)
        load(2'h0, 1'b0, 1'b1, 1'b1, 24'h000002, 16'h0004);
        @(negedge clk);
        `CHK(busy, 1'b1)
        pull(1'b1);
        `CHK(busy, 1'b0)
        load(2'h0, 1'b0, 1'b1, 1'b0, 24'h000000, 16'h0004);
        repeat (3) @(negedge clk);
        `CHK(busy, 1'b0)
        $display("test stop done");
    endtask

    initial
    begin
        #(25 * 20000);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        `CHK({pulse_out, dir_out, busy, sta_oe, stp_oe}, 5'h08)
        resetn <= 1'b1;
        t_single();
        t_dual();
        t_quad();
        t_sync();
        t_stop();
        give_verdict();
    end
endmodule // testbench
